// file: edge_sync.sv
// Three-stage input synchroniser with agreement of the last two stages
`timescale 1ns/1ns
module edge_sync
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic       next_dout;
    always_comb
    begin
        next_stage = {stage[1:0], din};
        next_dout  = (stage[2] == stage[1]) ? stage[1] : dout;
        if (!rst_n)
        begin
            next_stage = 3'h0;
            next_dout  = 1'h0;
        end
    end
    always_ff @(posedge sys_clk)
    begin
        stage <= next_stage;
        dout  <= next_dout;
    end
endmodule

// file: lcd_drive_checker.sv
// Concurrent checks on the ports of the display drive control
`timescale 1ns/1ns
module lcd_drive_checker
    import lcd_drive_pkg::*;
#(
    parameter int COMMONS_MAX = 8,
    parameter int SEGMENTS    = 46
)
(
    input wire logic                      sys_clk,
    input wire logic                      rst_n,
    input wire logic                      mcuReset,
    input wire logic                      watchdogReset,
    input wire logic                      deepSleep,
    input wire logic                      biasSelect,
    input wire logic [3:0]                topLevelRatioSelect,
    input wire logic [2:0]                biasResistorSelect,
    input wire logic                      displayEnable,
    input wire logic                      displayReset,
    input wire logic [3:0]                topLevelRatio,
    input wire logic [2:0]                ladderResistor,
    input wire logic [COMMONS_MAX-1:0]    commonOe,
    input wire logic [COMMONS_MAX*3-1:0]  commonLevel,
    input wire logic [SEGMENTS-1:0]       segmentOe,
    input wire logic [SEGMENTS*3-1:0]     segmentLevel,
    input wire logic [2:0]                activeCommon
);
    // ********************************
    // Helper and assertions
    // ********************************
    // Three-cycle windows absorb the one or two edges of output latency
    logic anyMid;
    always_comb
    begin
        anyMid = 1'h0;
        for (int i = 0; i < COMMONS_MAX; i++)
            anyMid |= commonLevel[i*3+:3] == 3'h2;
        for (int i = 0; i < SEGMENTS; i++)
            anyMid |= segmentLevel[i*3+:3] == 3'h2;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_sleep_reset: assert property (deepSleep[*3] |-> displayReset)
        else $error("display not reset in sleep");
    a_disable_reset: assert property (!displayEnable[*3] |-> displayReset)
        else $error("display not reset when disabled");
    a_float_mcu: assert property ((mcuReset && !(watchdogReset && deepSleep))[*3]
        |-> commonOe == '0 && segmentOe == '0) else $error("outputs not floating");
    a_low_reset: assert property ((displayReset && !mcuReset)[*3]
        |-> commonOe == '1 && commonLevel == '0) else $error("outputs not low");
    a_watchdog_sleep: assert property ((mcuReset && watchdogReset && deepSleep)[*3]
        |-> commonOe == '1) else $error("watchdog in sleep floated outputs");
    a_third_levels: assert property (!biasSelect[*3] |-> !anyMid)
        else $error("middle level used with third bias");
    a_scan_order: assert property (!displayReset && !$past(displayReset) && $changed(activeCommon)
        |-> activeCommon == $past(activeCommon) + 3'h1 || activeCommon == 3'h0) else $error("bad scan");
    a_frame_restart: assert property (displayReset[*2] |-> activeCommon == 3'h0)
        else $error("scan not held at first common");
    a_enable_cleared: assert property ($rose(rst_n) |-> !displayEnable)
        else $error("enable set after reset");
    a_ladder_select: assert property ($stable({topLevelRatioSelect, biasResistorSelect})[*3]
        |-> {topLevelRatio, ladderResistor} == {topLevelRatioSelect, biasResistorSelect}) else $error("bad ladder");
endmodule
bind lcd_drive_ctrl lcd_drive_checker #(.COMMONS_MAX(COMMONS_MAX), .SEGMENTS(SEGMENTS)) i_lcd_drive_checker (.*);

// file: lcd_drive_ctrl.sv
// Reset, frame sequencing and level selection of the segment display driver
`timescale 1ns/1ns
module lcd_drive_ctrl
    import lcd_drive_pkg::*;
#(
    parameter int COMMONS_MAX = 8,
    parameter int SEGMENTS    = 46
)
(
    input  wire logic                        sys_clk,
    input  wire logic                        rst_n,
    input  wire logic                        sub_clock,
    input  wire logic                        mcuReset,
    input  wire logic                        watchdogReset,
    input  wire logic                        deepSleep,
    input  wire logic                        displayEnableWrite,
    input  wire logic                        displayEnableData,
    input  wire logic [1:0]                  dutySelect,
    input  wire logic                        biasSelect,
    input  wire logic                        waveformSelect,
    input  wire logic [3:0]                  topLevelRatioSelect,
    input  wire logic [2:0]                  biasResistorSelect,
    input  wire logic [SEGMENTS*8-1:0]       segmentData,
    output logic                             displayEnable,
    output logic                             displayReset,
    output logic [3:0]                       topLevelRatio,
    output logic [2:0]                       ladderResistor,
    output logic                             ladderOn,
    output logic [COMMONS_MAX-1:0]           commonOe,
    output logic [COMMONS_MAX*3-1:0]         commonLevel,
    output logic [SEGMENTS-1:0]              segmentOe,
    output logic [SEGMENTS*3-1:0]            segmentLevel,
    output logic [2:0]                       activeCommon
);
    // ********************************
    // Sub-clock synchroniser
    // ********************************
    logic subSync;
    edge_sync subSyncInst
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .din     (sub_clock),
        .dout    (subSync)
    );

    // ********************************
    // Control state
    // ********************************
    drive_state_t state;
    drive_state_t next_state;
    logic         subPrev;
    logic [2:0]   divCount;
    logic [2:0]   slot;
    logic         phase;
    logic         frameOdd;
    logic         next_displayEnable;
    logic         next_subPrev;
    logic [2:0]   next_divCount;
    logic [2:0]   next_slot;
    logic         next_phase;
    logic         next_frameOdd;
    logic         tick;
    logic         realMcuReset;
    logic         holdReset;
    logic [2:0]   lastSlot;
    logic         next_displayReset;
    logic [3:0]   next_topLevelRatio;
    logic [2:0]   next_ladderResistor;
    logic         next_ladderOn;
    logic [2:0]   next_activeCommon;

    always_comb
    begin
        // Watchdog time-out during sleep leaves the display alone
        realMcuReset = mcuReset && !(watchdogReset && deepSleep);
        holdReset    = !displayEnable || deepSleep;
        case (dutySelect)
            DUTY_SIXTH:  lastSlot = COMMONS_SIXTH - 3'h1;
            DUTY_EIGHTH: lastSlot = COMMONS_EIGHTH - 3'h1;
            default:     lastSlot = COMMONS_QUARTER - 3'h1;
        endcase
        tick = subSync && !subPrev && (divCount == 3'(SUB_CLOCK_DIV - 1));
        next_subPrev       = subSync;
        next_divCount      = (subSync && !subPrev) ? divCount + 3'h1 : divCount;
        next_displayEnable = displayEnableWrite ? displayEnableData : displayEnable;
        next_slot          = slot;
        next_phase         = phase;
        next_frameOdd      = frameOdd;
        if (realMcuReset)
            next_state = DRIVE_FLOAT;
        else if (holdReset)
            next_state = DRIVE_LOW;
        else
            next_state = DRIVE_RUN;
        if (state != DRIVE_RUN)
        begin
            next_slot     = 3'h0;
            next_phase    = 1'h0;
            next_frameOdd = 1'h0;
        end
        else if (tick)
        begin
            // Type A flips polarity inside each slot, type B per frame
            if (!waveformSelect && !phase)
                next_phase = 1'h1;
            else
            begin
                next_phase = 1'h0;
                if (slot == lastSlot)
                begin
                    next_slot     = 3'h0;
                    next_frameOdd = !frameOdd;
                end
                else
                    next_slot = slot + 3'h1;
            end
        end
        next_displayReset   = (next_state != DRIVE_RUN);
        next_topLevelRatio  = topLevelRatioSelect;
        next_ladderResistor = biasResistorSelect;
        next_ladderOn       = (next_state == DRIVE_RUN);
        next_activeCommon   = next_slot;
        if (!rst_n)
        begin
            next_state          = DRIVE_LOW;
            next_subPrev        = 1'h0;
            next_divCount       = 3'h0;
            next_displayEnable  = ENABLE_RESET;
            next_slot           = 3'h0;
            next_phase          = 1'h0;
            next_frameOdd       = 1'h0;
            next_displayReset   = 1'h1;
            next_topLevelRatio  = 4'h0;
            next_ladderResistor = 3'h0;
            next_ladderOn       = 1'h0;
            next_activeCommon   = 3'h0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        state         <= next_state;
        subPrev       <= next_subPrev;
        divCount      <= next_divCount;
        displayEnable <= next_displayEnable;
        slot          <= next_slot;
        phase         <= next_phase;
        frameOdd      <= next_frameOdd;
        displayReset  <= next_displayReset;
        topLevelRatio <= next_topLevelRatio;
        ladderResistor <= next_ladderResistor;
        ladderOn      <= next_ladderOn;
        activeCommon  <= next_activeCommon;
    end

    // ********************************
    // Level generation
    // ********************************
    // Selected common swings rail to rail, unselected ones sit one step inside
    logic                     polarity;
    logic [2:0]               onHigh;
    logic [2:0]               offHigh;
    logic [2:0]               onLow;
    logic [2:0]               offLow;
    logic [2:0]               comSel;
    logic [2:0]               comUnsel;
    logic [COMMONS_MAX*3-1:0] next_commonLevel;
    logic [COMMONS_MAX-1:0]   next_commonOe;
    logic [SEGMENTS*3-1:0]    next_segmentLevel;
    logic [SEGMENTS-1:0]      next_segmentOe;

    always_comb
    begin
        // Polarity alternates each half so every pixel sees zero mean
        polarity = waveformSelect ? frameOdd : phase;
        // Unselected common near ground while selected is high keeps off pixels dark
        if (biasSelect)
        begin
            comSel   = polarity ? LVL_GND : LVL_TOP;
            comUnsel = polarity ? LVL_HIGH : LVL_LOW;
            onHigh   = polarity ? LVL_TOP : LVL_GND;
            offHigh  = LVL_MID;
        end
        else
        begin
            comSel   = polarity ? LVL_GND : LVL_TOP;
            comUnsel = polarity ? LVL_HIGH : LVL_LOW;
            onHigh   = polarity ? LVL_TOP : LVL_GND;
            offHigh  = polarity ? LVL_LOW : LVL_HIGH;
        end
        onLow  = onHigh;
        offLow = offHigh;
        for (int c = 0; c < COMMONS_MAX; c++)
        begin
            next_commonLevel[c*3 +: 3] = (3'(c) == slot) ? comSel : comUnsel;
            next_commonOe[c] = (state != DRIVE_FLOAT);
            if (state == DRIVE_LOW || ({1'h0, 3'(c)} > {1'h0, lastSlot}))
                next_commonLevel[c*3 +: 3] = LVL_GND;
        end
        for (int s = 0; s < SEGMENTS; s++)
        begin
            next_segmentLevel[s*3 +: 3] = segmentData[s*8 + 32'(slot)] ? onLow : offLow;
            next_segmentOe[s] = (state != DRIVE_FLOAT);
            if (state == DRIVE_LOW)
                next_segmentLevel[s*3 +: 3] = LVL_GND;
        end
        if (!rst_n)
        begin
            next_commonLevel  = '0;
            next_commonOe     = '0;
            next_segmentLevel = '0;
            next_segmentOe    = '0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        commonLevel    <= next_commonLevel;
        commonOe       <= next_commonOe;
        segmentLevel   <= next_segmentLevel;
        segmentOe      <= next_segmentOe;
    end
endmodule

// file: lcd_drive_pkg.sv
// Constants and types shared by the segment display drive logic
package lcd_drive_pkg;
    // ********************************
    // Encodings and reset values
    // ********************************
    localparam logic [1:0] DUTY_QUARTER   = 2'h0;
    localparam logic [1:0] DUTY_SIXTH     = 2'h1;
    localparam logic [1:0] DUTY_EIGHTH    = 2'h2;
    localparam logic [2:0] COMMONS_QUARTER = 3'h4;
    localparam logic [2:0] COMMONS_SIXTH   = 3'h6;
    localparam logic [2:0] COMMONS_EIGHTH  = 3'h0;
    localparam int         SUB_CLOCK_DIV  = 8;
    localparam logic       ENABLE_RESET   = 1'h0;
    localparam int         LEVEL_WIDTH    = 3;
    // Drive levels, 0 is ground, TOP is the selected top level
    localparam logic [2:0] LVL_GND        = 3'h0;
    localparam logic [2:0] LVL_TOP        = 3'h4;
    localparam logic [2:0] LVL_LOW        = 3'h1;
    localparam logic [2:0] LVL_MID        = 3'h2;
    localparam logic [2:0] LVL_HIGH       = 3'h3;
    typedef enum logic [2:0]
    {
        DRIVE_FLOAT = 3'h1,
        DRIVE_LOW   = 3'h2,
        DRIVE_RUN   = 3'h4
    } drive_state_t;
endpackage

// file: lcd_panel_model.sv
// Passive panel model summing the voltage across one pixel
`timescale 1ns/1ns
module lcd_panel_model
(
    input wire logic       sys_clk,
    input wire logic       clear,
    input wire logic       comOe,
    input wire logic [2:0] comLvl,
    input wire logic       segOe,
    input wire logic [2:0] segLvl,
    output logic [31:0]    dcSum
);
    // A floating line puts no charge on the glass
    always_ff @(posedge sys_clk)
        if (clear)
            dcSum <= 0;
        else if (comOe && segOe)
            dcSum <= dcSum + 32'(comLvl) - 32'(segLvl);
endmodule

// file: test_lcd_drive_reset_and_waveform_control.sv
// Self-checking bench of the display drive control
`timescale 1ns/1ns
module test_lcd_drive_reset_and_waveform_control import lcd_drive_pkg::*;;
    logic        sys_clk, rst_n, sub_clock, mcuReset, watchdogReset, deepSleep, clear;
    logic        displayEnableWrite, displayEnableData, biasSelect, waveformSelect;
    logic        displayEnable, displayReset, ladderOn;
    logic [1:0]  dutySelect, segmentOe;
    logic [3:0]  topLevelRatioSelect, topLevelRatio;
    logic [2:0]  biasResistorSelect, ladderResistor, activeCommon;
    logic [15:0] segmentData;
    logic [7:0]  commonOe;
    logic [23:0] commonLevel;
    logic [5:0]  segmentLevel;
    int          num_errors, num_checks;
    logic [31:0] dcSum;
    lcd_drive_ctrl #(.SEGMENTS(2)) i_lcd_drive_ctrl (.*);
    lcd_panel_model i_lcd_panel_model (.sys_clk(sys_clk), .clear(clear), .comOe(commonOe[0]),
        .comLvl(commonLevel[2:0]), .segOe(segmentOe[0]), .segLvl(segmentLevel[2:0]), .dcSum(dcSum));
    // ********************************
    // Tasks
    // ********************************
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic setEn(input logic v);
        @(negedge sys_clk);
        displayEnableData = v;
        displayEnableWrite = 1'h1;
        @(negedge sys_clk);
        displayEnableWrite = 1'h0;
        repeat (4) @(negedge sys_clk);
    endtask
    // Counts cycles up to the next return of the scan to the first common
    task automatic wrap(output int n);
        logic [2:0] p;
        n = 0;
        do
        begin
            p = activeCommon;
            @(negedge sys_clk);
            n++;
        end
        while (!(activeCommon === 3'h0 && p !== 3'h0) && n < 5000);
    endtask
    task automatic t_power_on();
        chk("enable", 32'h0, displayEnable);
        repeat (3) @(negedge sys_clk);
        chk("reset", 32'h1, displayReset);
        chk("oe", 32'hff, commonOe);
        chk("ratio", 32'h9, topLevelRatio);
        chk("resistor", 32'h5, ladderResistor);
    endtask
    // Sub-clock period is four system cycles, so a tick is a fixed count
    task automatic t_mode(input logic [1:0] d, input logic b, input logic w, input int c);
        int n;
        setEn(1'h0);
        dutySelect = d;
        biasSelect = b;
        waveformSelect = w;
        setEn(1'h1);
        chk("run reset", 32'h0, displayReset);
        chk("ladder on", 32'h1, ladderOn);
        wrap(n);
        clear = 1'h1;
        @(negedge sys_clk);
        clear = 1'h0;
        wrap(n);
        wrap(n);
        chk("frame", c * (w ? 1 : 2) * SUB_CLOCK_DIV * 4, n);
        @(negedge sys_clk);
        chk("dc", 32'h0, dcSum);
        // Segment 0 is off on common 1, so it shows the off level there
        while (activeCommon !== 3'h1)
            @(negedge sys_clk);
        repeat (2) @(negedge sys_clk);
        chk("mid level", b, segmentLevel[2:0] == LVL_MID);
    endtask
    task automatic t_sleep();
        deepSleep = 1'h1;
        repeat (4) @(negedge sys_clk);
        chk("sleep reset", 32'h1, displayReset);
        chk("sleep level", 32'h0, commonLevel);
        mcuReset = 1'h1;
        watchdogReset = 1'h1;
        repeat (4) @(negedge sys_clk);
        chk("watchdog oe", 32'hff, commonOe);
        deepSleep = 1'h0;
        watchdogReset = 1'h0;
        repeat (4) @(negedge sys_clk);
        chk("float com", 32'h0, commonOe);
        chk("float seg", 32'h0, segmentOe);
        mcuReset = 1'h0;
        setEn(1'h0);
        chk("off reset", 32'h1, displayReset);
        chk("ladder", 32'h0, ladderOn);
    endtask
    // ********************************
    // Clocks, watchdog and sequence
    // ********************************
    initial
    begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        sub_clock = 1'h0;
        #3;
        forever #20 sub_clock = ~sub_clock;
    end
    // Whole sequence needs under 10000 cycles, so twice that means a hang
    initial
    begin
        #200000;
        num_errors++;
        test_done();
    end
    initial
    begin
        {rst_n, mcuReset, watchdogReset, deepSleep, displayEnableWrite, displayEnableData} = '0;
        {biasSelect, waveformSelect, dutySelect} = '0;
        topLevelRatioSelect = 4'h9;
        biasResistorSelect = 3'h5;
        segmentData = 16'h00a5;
        clear = 1'h1;
        num_errors = 0;
        num_checks = 0;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'h1;
        clear = 1'h0;
        t_power_on();
        t_mode(2'h0, 1'h0, 1'h0, 4);
        t_mode(2'h1, 1'h0, 1'h1, 6);
        t_mode(2'h2, 1'h1, 1'h0, 8);
        t_mode(2'h2, 1'h1, 1'h1, 8);
        t_mode(2'h3, 1'h0, 1'h0, 4);
        t_sleep();
        test_done();
    end
endmodule
